// ==== include/shf_regs.svh ====
// constants for the sync header stream fec link ends
// assumes inclusion by bare name from the package, whose macros both ends use
`ifndef SHF_REGS_SVH
`define SHF_REGS_SVH

// ----------------------------------------------------------------
// structure
// ----------------------------------------------------------------
`define SHF_LANES      2
`define SHF_PAY_W      64
`define SHF_PAR_W      26
`define SHF_POLY       26'h022_0211
`define SHF_MODE_FEC   2'h2
`define SHF_LAST_BLK   5'h1f
`define SHF_EOEMB_POS  5'h16
`define SHF_PAR_DONE   5'h1a
`define SHF_PILOT_RX   5'h01
`define SHF_PILOT_TX   5'h10
`define SHF_SH_ONE     2'h1
`define SHF_SH_ZERO    2'h2

// ----------------------------------------------------------------
// receiver monitoring thresholds and elastic buffer depth
// ----------------------------------------------------------------
`define SHF_BLK_GOOD   7'h3f
`define SHF_BLK_ERR    3'h3
`define SHF_BLK_WIN    6'h3f
`define SHF_MB_CONF    3'h3
`define SHF_MB_ERR     3'h2
`define SHF_MB_WIN     8'hff
`define SHF_EMB_ERR    3'h2
`define SHF_EMB_WIN    4'hf
`define SHF_EB_DEPTH   8

`endif

// ==== include/shf_pkg.sv ====
// types and shared coding functions of the fec sync header link
// assumes shf_regs.svh on the include path
`include "shf_regs.svh"

package shf_pkg;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef logic [`SHF_PAY_W-1:0]   shf_pay_t;
   typedef logic [`SHF_PAR_W-1:0]   shf_par_t;
   typedef logic [`SHF_PAY_W+1:0]   shf_blk_t;
   typedef shf_pay_t [`SHF_LANES-1:0] shf_lane_pay_t;
   typedef shf_par_t [`SHF_LANES-1:0] shf_lane_par_t;
   typedef shf_blk_t [`SHF_LANES-1:0] shf_lanes_t;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // one block of payload through the fire code divider, msb first
   function automatic shf_par_t shf_fec_step(input shf_par_t s,
                                             input shf_pay_t d);
      shf_par_t r;
      logic     fb;
      r = s;
      for (int i = `SHF_PAY_W-1; i >= 0; i--) begin
         fb = d[i] ^ r[`SHF_PAR_W-1];
         r  = {r[`SHF_PAR_W-2:0], 1'b0} ^ (fb ? `SHF_POLY : '0);
      end
      return r;
   endfunction

   // stream word, bit p is the header bit of block p
   function automatic logic [31:0] shf_shs_pack(input shf_par_t p,
                                                input logic     eo);
      logic [31:0] w;
      w = '0;
      for (int j = 0; j < 22; j++) begin
         w[j] = p[25-j];
      end
      w[22]    = eo;
      w[23]    = p[3];
      w[26:24] = {p[0], p[1], p[2]};
      w[31:27] = `SHF_PILOT_TX;
      return w;
   endfunction

   // received parity from the window taken at stream bit 26
   function automatic shf_par_t shf_shs_par(input logic [31:0] win);
      return {win[26:5], win[3:0]};
   endfunction

endpackage

// ==== include/shf_link_if.sv ====
// link between the transmit end and the receive end
// assumes both ends on one clock; blocks are already framed
`timescale 1ns/100ps
`default_nettype none

interface shf_link_if;
   logic               vld;
   shf_pkg::shf_lanes_t blk;

   modport tx (output vld, output blk);
   modport rx (input vld, input blk);
endinterface

`default_nettype wire

// ==== design/shf_tx_end.sv ====
// transmit end: fec parity and pilot into the sync header stream
// assumes one block per lane per valid cycle, sysref from a pin
`timescale 1ns/100ps
`default_nettype none

module shf_tx_end (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   srst,
   // configuration
   input  wire logic [1:0]             sync_header_mode_select,
   input  wire logic [5:0]             mb_per_emb,
   // system reference pin
   input  wire logic                   sysref,
   // scrambled payload
   input  wire logic                   pay_vld,
   input  wire shf_pkg::shf_lane_pay_t pay,
   // link
   shf_link_if.tx                      lk,
   // local extended multiblock start
   output logic                        lemc_pulse
);
   import shf_pkg::*;

   // ----------------------------------------------------------------
   // sysref crossing and lemc phase
   // ----------------------------------------------------------------
   logic       sr_m_q;
   logic       sr_s_q;
   logic       sr_d_q;
   logic       sr_edge;
   logic [4:0] blk_q;
   logic [5:0] mb_q;
   logic       last_mb;
   logic       last_blk;
   logic       fec_on;
   shf_lanes_t blk_d;

   always_ff @(posedge clk) begin
      if (srst) begin
         sr_m_q <= 1'b0;
         sr_s_q <= 1'b0;
         sr_d_q <= 1'b0;
      end else begin
         sr_m_q <= sysref;
         sr_s_q <= sr_m_q;
         sr_d_q <= sr_s_q;
      end
   end

   assign sr_edge  = sr_s_q & ~sr_d_q;
   assign last_mb  = mb_q == (mb_per_emb - 6'h01);
   assign last_blk = blk_q == `SHF_LAST_BLK;
   assign fec_on   = sync_header_mode_select == `SHF_MODE_FEC;

   // block and multiblock counters restart on sysref
   always_ff @(posedge clk) begin
      if (srst || sr_edge) begin
         blk_q <= '0;
         mb_q  <= '0;
      end else if (pay_vld) begin
         blk_q <= blk_q + 5'h01;
         if (last_blk) begin
            mb_q <= last_mb ? 6'h00 : mb_q + 6'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // per lane parity and header mapping
   // ----------------------------------------------------------------
   for (genvar g = 0; g < `SHF_LANES; g++) begin : g_lane
      shf_par_t    lfsr_q;
      shf_par_t    cur_q;
      shf_par_t    step;
      logic [31:0] shs;

      assign step = shf_fec_step(lfsr_q, pay[g]);
      // parity of the finished multiblock rides in the next one
      assign shs = shf_shs_pack(fec_on ? cur_q : '0, last_mb);

      always_ff @(posedge clk) begin
         if (srst || sr_edge) begin
            lfsr_q <= '0;
            cur_q  <= '0;
         end else if (pay_vld) begin
            if (last_blk) begin
               cur_q  <= step;
               lfsr_q <= '0;
            end else begin
               lfsr_q <= step;
            end
         end
      end

      // header never enters the divider; parity done by stream bit 26
      assign blk_d[g] = {pay[g], shs[blk_q] ? `SHF_SH_ONE
                                            : `SHF_SH_ZERO};
   end

   // ----------------------------------------------------------------
   // link register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         lk.vld     <= 1'b0;
         lk.blk     <= '0;
         lemc_pulse <= 1'b0;
      end else begin
         lk.vld     <= pay_vld;
         lk.blk     <= blk_d;
         lemc_pulse <= pay_vld && (blk_q == 5'h00) && (mb_q == 6'h00);
      end
   end

endmodule

`default_nettype wire

// ==== design/shf_rx_end.sv ====
// receive end: alignment, monitoring, syndrome and lane release
// assumes framed blocks from the link, sysref from a pin
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - fec parity used when mode is two
// - 26 parity bits over 2048 payload bits
// - parity sent in the following multiblock
// - receiver forms syndrome; zero means clean
// - first bit error found after 58 blocks
// - parity bits placed at fixed stream positions
// - stream bits 27 to 31 are 00001
// - bit 22 marks last multiblock only
// - pilot confirmed at same place repeatedly
// - fire code generator polynomial of degree 26
// - divider cleared per multiblock, headers excluded
// - syndrome only; burst correction is downstream
// - all three alignments before lane alignment
// - buffering starts at next extended multiblock
// - release at first release point after buffering
// - release point outside arrival variation region
// - repeated header errors drop block lock
// - repeated pilot errors restart multiblock search
// - repeated end marker errors restart alignment
// - after pilot or end marker loss wait for sysref first
// - 32 blocks per multiblock, E per extended
// - header 01 carries one, 10 zero
// - sysref resets local extended multiblock clock
module shf_rx_end (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   srst,
   // configuration
   input  wire logic [5:0]             mb_per_emb,
   input  wire logic [10:0]            rbd,
   // system reference pin
   input  wire logic                   sysref,
   // link
   shf_link_if.rx                      lk,
   // released data
   output logic                        data_vld,
   output wire shf_pkg::shf_lane_pay_t data,
   output logic                        released,
   // error check
   output wire shf_pkg::shf_lane_par_t syndrome,
   output wire logic [`SHF_LANES-1:0]  synd_vld,
   output wire logic [`SHF_LANES-1:0]  fec_err,
   // alignment status
   output wire logic [`SHF_LANES-1:0]  blk_lock,
   output wire logic [`SHF_LANES-1:0]  mb_lock,
   output wire logic [`SHF_LANES-1:0]  emb_lock,
   output wire logic [`SHF_LANES-1:0]  sysref_req
);
   import shf_pkg::*;

   // ----------------------------------------------------------------
   // sysref crossing and local extended multiblock clock
   // ----------------------------------------------------------------
   logic                  sr_m_q;
   logic                  sr_s_q;
   logic                  sr_d_q;
   logic                  sr_edge;
   logic [10:0]           lemc_q;
   logic [10:0]           lemc_last;
   logic [`SHF_LANES-1:0] go_w;
   logic                  all_emb;
   logic                  all_go;

   always_ff @(posedge clk) begin
      if (srst) begin
         sr_m_q <= 1'b0;
         sr_s_q <= 1'b0;
         sr_d_q <= 1'b0;
      end else begin
         sr_m_q <= sysref;
         sr_s_q <= sr_m_q;
         sr_d_q <= sr_s_q;
      end
   end

   assign sr_edge   = sr_s_q & ~sr_d_q;
   assign lemc_last = {mb_per_emb - 6'h01, `SHF_LAST_BLK};
   assign all_emb   = &emb_lock;
   assign all_go    = &go_w;

   always_ff @(posedge clk) begin
      if (srst || sr_edge) begin
         lemc_q <= '0;
      end else if (lk.vld) begin
         lemc_q <= (lemc_q == lemc_last) ? 11'h000 : lemc_q + 11'h001;
      end
   end

   // rbd is the user's job to keep clear of the arrival spread
   always_ff @(posedge clk) begin
      if (srst || !all_go) begin
         released <= 1'b0;
         data_vld <= 1'b0;
      end else begin
         if (lk.vld && (lemc_q == rbd)) begin
            released <= 1'b1;
         end
         data_vld <= released && lk.vld;
      end
   end

   // ----------------------------------------------------------------
   // per lane alignment, monitoring, syndrome and elastic buffer
   // ----------------------------------------------------------------
   for (genvar g = 0; g < `SHF_LANES; g++) begin : g_lane
      logic [1:0]  hdr;
      shf_pay_t    pay;
      logic        hok;
      logic        shb;
      logic        pilot;
      logic [31:0] win;
      logic [31:0] shs_q;
      logic        bl_q;
      logic [6:0]  bgood_q;
      logic [2:0]  berr_q;
      logic [5:0]  bwin_q;
      logic [4:0]  idx_q;
      logic [4:0]  cand_q;
      logic [2:0]  hits_q;
      logic [2:0]  mberr_q;
      logic [7:0]  mbwin_q;
      logic        ml_q;
      logic [5:0]  mbc_q;
      logic        el_q;
      logic [2:0]  emberr_q;
      logic [3:0]  embwin_q;
      logic        eo_bad;
      logic        rs_q;
      logic        mb_lose;
      logic        emb_lose;
      shf_par_t    lfsr_q;
      shf_par_t    lpar_q;
      shf_par_t    synd_q;
      logic        have_q;
      logic        sv_q;
      logic        err_q;
      logic        go_q;
      logic [2:0]  wp_q;
      logic [2:0]  rp_q;
      shf_pay_t    mem_q [`SHF_EB_DEPTH];
      shf_pay_t    dout_q;

      assign hdr   = lk.blk[g][1:0];
      assign pay   = lk.blk[g][`SHF_PAY_W+1:2];
      assign hok   = (hdr == `SHF_SH_ONE) || (hdr == `SHF_SH_ZERO);
      assign shb   = hdr == `SHF_SH_ONE;
      assign win   = {shs_q[30:0], shb};
      assign pilot = win[4:0] == `SHF_PILOT_RX;
      assign eo_bad = shb != (mbc_q == (mb_per_emb - 6'h01));
      assign mb_lose = lk.vld && ml_q && (idx_q == `SHF_LAST_BLK)
                       && !pilot && (mberr_q == `SHF_MB_ERR);
      assign emb_lose = lk.vld && el_q && (idx_q == `SHF_EOEMB_POS)
                        && eo_bad && (emberr_q == `SHF_EMB_ERR);

      always_ff @(posedge clk) begin
         if (srst) begin
            shs_q <= '0;
         end else if (lk.vld) begin
            shs_q <= win;
         end
      end

      // block lock: three bad headers tolerated per window, a fourth is not
      always_ff @(posedge clk) begin
         if (srst) begin
            bl_q    <= 1'b0;
            bgood_q <= '0;
            berr_q  <= '0;
            bwin_q  <= '0;
         end else if (lk.vld) begin
            bwin_q <= bwin_q + 6'h01;
            if (!bl_q) begin
               bgood_q <= hok ? bgood_q + 7'h01 : 7'h00;
               if (hok && (bgood_q == `SHF_BLK_GOOD)) begin
                  bl_q   <= 1'b1;
                  berr_q <= '0;
               end
            end else if (!hok) begin
               if (berr_q == `SHF_BLK_ERR) begin
                  bl_q    <= 1'b0;
                  bgood_q <= '0;
               end else begin
                  berr_q <= berr_q + 3'h1;
               end
            end else if (bwin_q == `SHF_BLK_WIN) begin
               berr_q <= '0;
            end
         end
      end

      // multiblock search needs the pilot at one phase several times
      always_ff @(posedge clk) begin
         if (srst || !bl_q || rs_q) begin
            ml_q    <= 1'b0;
            hits_q  <= '0;
            cand_q  <= '0;
            idx_q   <= '0;
            mberr_q <= '0;
            mbwin_q <= '0;
         end else if (lk.vld) begin
            idx_q <= idx_q + 5'h01;
            if (!ml_q) begin
               if (pilot && (hits_q != 3'h0) && (idx_q == cand_q)) begin
                  hits_q <= hits_q + 3'h1;
                  if (hits_q == `SHF_MB_CONF) begin
                     ml_q    <= 1'b1;
                     idx_q   <= '0;
                     mberr_q <= '0;
                  end
               end else if (pilot && (hits_q == 3'h0)) begin
                  cand_q <= idx_q;
                  hits_q <= 3'h1;
               end else if (idx_q == cand_q) begin
                  hits_q <= '0;
               end
            end else begin
               mbwin_q <= mbwin_q + 8'h01;
               if ((idx_q == `SHF_LAST_BLK) && !pilot) begin
                  mberr_q <= mberr_q + 3'h1;
               end else if (mbwin_q == `SHF_MB_WIN) begin
                  mberr_q <= '0;
               end
            end
         end
      end

      // extended multiblock phase from the end marker bit
      always_ff @(posedge clk) begin
         if (srst || !ml_q) begin
            el_q     <= 1'b0;
            mbc_q    <= '0;
            emberr_q <= '0;
            embwin_q <= '0;
         end else if (lk.vld) begin
            if (idx_q == `SHF_EOEMB_POS) begin
               if (!el_q && shb) begin
                  el_q  <= 1'b1;
                  mbc_q <= mb_per_emb - 6'h01;
               end else if (el_q && eo_bad) begin
                  emberr_q <= emberr_q + 3'h1;
               end
            end
            if (el_q && (idx_q == `SHF_LAST_BLK)) begin
               mbc_q <= (mbc_q == (mb_per_emb - 6'h01)) ? 6'h00
                                                         : mbc_q + 6'h01;
               if (mbc_q == (mb_per_emb - 6'h01)) begin
                  embwin_q <= embwin_q + 4'h1;
                  if (embwin_q == `SHF_EMB_WIN) begin
                     emberr_q <= '0;
                  end
               end
            end
         end
      end

      // loss holds the search until the lemc is re-established
      always_ff @(posedge clk) begin
         if (srst) begin
            rs_q <= 1'b0;
         end else if (mb_lose || emb_lose) begin
            rs_q <= 1'b1;
         end else if (sr_edge) begin
            rs_q <= 1'b0;
         end
      end

      // syndrome as soon as the last parity bit has landed
      always_ff @(posedge clk) begin
         if (srst || !ml_q) begin
            lfsr_q <= '0;
            lpar_q <= '0;
            have_q <= 1'b0;
         end else if (lk.vld) begin
            if (idx_q == `SHF_LAST_BLK) begin
               lpar_q <= shf_fec_step(lfsr_q, pay);
               lfsr_q <= '0;
               have_q <= 1'b1;
            end else begin
               lfsr_q <= shf_fec_step(lfsr_q, pay);
            end
         end
      end

      // only the syndrome is produced; burst trapping is downstream
      always_ff @(posedge clk) begin
         if (srst) begin
            synd_q <= '0;
            sv_q   <= 1'b0;
            err_q  <= 1'b0;
         end else begin
            sv_q <= lk.vld && ml_q && have_q && (idx_q == `SHF_PAR_DONE);
            if (lk.vld && ml_q && have_q && (idx_q == `SHF_PAR_DONE)) begin
               synd_q <= lpar_q ^ shf_shs_par(win);
               err_q  <= (lpar_q ^ shf_shs_par(win)) != '0;
            end
         end
      end

      // elastic buffer, filled from the next extended multiblock
      always_ff @(posedge clk) begin
         if (srst || !all_emb) begin
            go_q <= 1'b0;
            wp_q <= '0;
         end else if (lk.vld) begin
            if (go_q || ((idx_q == 5'h00) && (mbc_q == 6'h00))) begin
               go_q        <= 1'b1;
               mem_q[wp_q] <= pay;
               wp_q        <= wp_q + 3'h1;
            end
         end
      end

      always_ff @(posedge clk) begin
         if (srst || !released) begin
            rp_q   <= '0;
            dout_q <= '0;
         end else if (lk.vld) begin
            dout_q <= mem_q[rp_q];
            rp_q   <= rp_q + 3'h1;
         end
      end

      assign go_w[g]       = go_q;
      assign data[g]       = dout_q;
      assign syndrome[g]   = synd_q;
      assign synd_vld[g]   = sv_q;
      assign fec_err[g]    = err_q;
      assign blk_lock[g]   = bl_q;
      assign mb_lock[g]    = ml_q;
      assign emb_lock[g]   = el_q;
      assign sysref_req[g] = rs_q;
   end

endmodule

`default_nettype wire

// ==== sim/shf_props.sv ====
// checker for the fec sync header stream on the link
// assumes instantiation beside the link interface, one clock
`timescale 1ns/100ps
`default_nettype none

module shf_props (
   // clock and reset
   input wire logic                clk,
   input wire logic                srst,
   // configuration
   input wire logic [1:0]          sync_header_mode_select,
   input wire logic [5:0]          mb_per_emb,
   // link
   input wire logic                vld,
   input wire shf_pkg::shf_lanes_t blk
);
   import shf_pkg::*;
   logic [4:0] idx_q;
   logic [5:0] mb_q;
   logic       have_q;
   logic       eo;
   logic [1:0] sb;
   shf_par_t   run_q [2];
   shf_par_t   par_q [2];

   // ----------------------------------------------------------------
   // reference model of the stream
   // ----------------------------------------------------------------
   function automatic shf_par_t div64(shf_par_t s, shf_pay_t d);
      shf_par_t r;
      r = s;
      for (int i = 63; i >= 0; i--) begin
         r = {r[24:0], 1'b0} ^ ((d[i] ^ r[25]) ? 26'h022_0211 : 26'h000_0000);
      end
      return r;
   endfunction

   function automatic logic xbit(shf_par_t p, logic [4:0] n, logic e);
      if (n < 5'h16) return p[5'h19 - n];
      if (n == 5'h16) return e;
      if (n < 5'h1b) return p[5'h1a - n];
      return n == 5'h1f;
   endfunction

   assign eo = mb_q == mb_per_emb - 6'h01;
   assign sb = {blk[1][1:0] == 2'h1, blk[0][1:0] == 2'h1};

   always_ff @(posedge clk) begin
      if (srst) begin
         idx_q  <= 5'h00;
         mb_q   <= 6'h00;
         have_q <= 1'b0;
      end else if (vld) begin
         idx_q <= idx_q + 5'h01;
         if (idx_q == 5'h1f) begin
            have_q <= 1'b1;
            mb_q   <= eo ? 6'h00 : mb_q + 6'h01;
         end
      end
   end

   // divider restarts at block 0, headers never enter it
   always_ff @(posedge clk) begin
      for (int l = 0; l < 2; l++) begin
         if (srst) begin
            run_q[l] <= '0;
            par_q[l] <= '0;
         end else if (vld) begin
            run_q[l] <= div64(idx_q == 5'h00 ? '0 : run_q[l], blk[l][65:2]);
            if (idx_q == 5'h1f) begin
               par_q[l] <= div64(run_q[l], blk[l][65:2]);
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_hdr_legal: assert property (
      vld |-> blk[0][1:0] inside {2'h1, 2'h2} && blk[1][1:0] inside {2'h1, 2'h2})
      else $error("illegal header pair on link");
   chk_stream_lane0: assert property (
      vld && have_q && sync_header_mode_select == 2'h2
      |-> sb[0] == xbit(par_q[0], idx_q, eo))
      else $error("lane 0 stream bit differs from model");
   chk_stream_lane1: assert property (
      vld && have_q && sync_header_mode_select == 2'h2
      |-> sb[1] == xbit(par_q[1], idx_q, eo))
      else $error("lane 1 stream bit differs from model");
   chk_pilot_zeros: assert property (
      vld && idx_q inside {[5'h1b:5'h1e]} |-> sb == 2'h0)
      else $error("pilot zero missing");
   chk_pilot_end: assert property (
      vld && idx_q == 5'h1f |-> sb == 2'h3)
      else $error("pilot one missing at block 31");
   chk_eoemb_mark: assert property (
      vld && idx_q == 5'h16 |-> sb == {2{eo}})
      else $error("end of extended multiblock bit wrong");
   chk_par_off: assert property (
      vld && sync_header_mode_select != 2'h2 && idx_q < 5'h16 |-> sb == 2'h0)
      else $error("parity sent outside fec mode");
   chk_reset_quiet: assert property (
      $fell(srst) |-> !vld)
      else $error("link valid right after reset");
endmodule

`default_nettype wire

// ==== sim/sync_header_fec_alignment_bench.sv ====
// bench: both ends joined, plus a receive end on a faulted link copy
// assumes package, interface, both ends and checker compiled first
`timescale 1ns/100ps
`default_nettype none

module sync_header_fec_alignment_bench;
   import shf_pkg::*;
   logic          clk, srst, run, pay_vld, sref_f, dv, rel, lemc;
   logic [1:0]    mode, inj, sv, fe, bl, ml, el, sq;
   logic [1:0]    sv_f, fe_f, bl_f, ml_f, el_f, sq_f;
   logic [5:0]    emb;
   logic [10:0]   rbd;
   logic [4:0]    bidx;
   logic [31:0]   cnt;
   logic [25:0]   s_or;
   shf_lane_pay_t pay, data;
   shf_lane_par_t synd, synd_f;
   shf_lanes_t    emask;
   int            fail_count, n_tests, cyc, s_n, inj_cyc, err_cyc;

   shf_link_if lk ();
   shf_link_if lk_f ();
   assign lk_f.vld = lk.vld;
   assign lk_f.blk = lk.blk ^ emask;

   shf_tx_end u_shf_tx_end (.clk(clk), .srst(srst),
      .sync_header_mode_select(mode), .mb_per_emb(emb), .sysref(1'b0),
      .pay_vld(pay_vld), .pay(pay), .lk(lk.tx), .lemc_pulse(lemc));
   shf_rx_end u_shf_rx_end (.clk(clk), .srst(srst), .mb_per_emb(emb),
      .rbd(rbd), .sysref(1'b0), .lk(lk.rx), .data_vld(dv), .data(data),
      .released(rel), .syndrome(synd), .synd_vld(sv), .fec_err(fe),
      .blk_lock(bl), .mb_lock(ml), .emb_lock(el), .sysref_req(sq));
   // second receiver sees deliberate link faults only
   shf_rx_end u_shf_rx_end_f (.clk(clk), .srst(srst), .mb_per_emb(emb),
      .rbd(rbd), .sysref(sref_f), .lk(lk_f.rx), .data_vld(), .data(),
      .released(), .syndrome(synd_f), .synd_vld(sv_f), .fec_err(fe_f),
      .blk_lock(bl_f), .mb_lock(ml_f), .emb_lock(el_f), .sysref_req(sq_f));
   shf_props u_shf_props (.clk(clk), .srst(srst),
      .sync_header_mode_select(mode), .mb_per_emb(emb),
      .vld(lk.vld), .blk(lk.blk));

   // ----------------------------------------------------------------
   // feeder, fault mask and monitor
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      pay_vld <= run;
      if (run) begin
         cnt    <= cnt + 32'h0000_0001;
         pay[0] <= {cnt, ~cnt};
         pay[1] <= {~cnt, cnt};
      end
   end

   // 1: first payload bit, 2: broken header, 3: inverted pilot one
   always_comb begin
      emask = '0;
      if (inj == 2'h1 && bidx == 5'h00) emask[0][65] = 1'b1;
      if (inj == 2'h2) emask[0][0] = 1'b1;
      if (inj == 2'h3 && bidx == 5'h1f) emask[0][1:0] = 2'h3;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      bidx <= srst ? 5'h00 : bidx + 5'(lk.vld);
      if (sv[0]) begin
         s_n  <= s_n + 1;
         s_or <= s_or | synd[0];
      end
      if (lk.vld && emask[0][65] && inj_cyc == 0) inj_cyc <= cyc;
      if (sv_f[0] && fe_f[0] && err_cyc == 0) err_cyc <= cyc;
      if (dv) check("lane data", data[1], ~data[0]);
      if (lemc) check("lemc phase", 64'(bidx), 64'h0);
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [63:0] seen,
                        input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic do_reset(input logic [1:0] m);
      run  <= 1'b0;
      srst <= 1'b1;
      mode <= m;
      repeat (8) @(posedge clk);
      s_n     = 0;
      s_or    = '0;
      inj_cyc = 0;
      err_cyc = 0;
      srst <= 1'b0;
      @(posedge clk);
      run <= 1'b1;
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic t_mode_off();
      wait_n(320);
      check("blk lock", 64'(bl), 64'h3);
      check("mb lock", 64'(ml), 64'h3);
      check("fec err", 64'(fe), 64'h3);
   endtask

   task automatic t_lock();
      wait_n(400);
      check("all locks", 64'({bl, ml, el}), 64'h3f);
      check("no sysref req", 64'(sq), 64'h0);
      check("released", 64'(rel), 64'h1);
      check("synd seen", 64'(s_n != 0), 64'h1);
      check("synd clean", 64'(s_or), 64'h0);
   endtask

   task automatic t_fec_err();
      inj <= 2'h1;
      wait_n(32);
      inj <= 2'h0;
      wait_n(96);
      check("latency", 64'(err_cyc - inj_cyc), 64'd59);
      check("fec err ok", 64'(fe), 64'h0);
      wait_n(32);
      check("fec err gone", 64'(fe_f), 64'h0);
   endtask

   task automatic t_hdr_loss();
      inj <= 2'h2;
      @(posedge clk);
      inj <= 2'h0;
      wait_n(3);
      check("one bad hdr", 64'(bl_f), 64'h3);
      inj <= 2'h2;
      repeat (4) @(posedge clk);
      inj <= 2'h0;
      wait_n(3);
      check("hdr loss", 64'({bl_f, ml_f, sq_f}), 64'h28);
      wait_n(400);
      check("relock", 64'({ml_f, el_f}), 64'hf);
   endtask

   task automatic t_pilot_loss();
      inj <= 2'h3;
      repeat (160) @(posedge clk);
      inj <= 2'h0;
      wait_n(320);
      check("pilot loss", 64'({ml_f[0], sq_f[0]}), 64'h1);
      sref_f <= 1'b1;
      repeat (4) @(posedge clk);
      sref_f <= 1'b0;
      wait_n(400);
      check("after sysref", 64'({ml_f, sq_f}), 64'hc);
   endtask

   // ----------------------------------------------------------------
   // clock, sequence, watchdog
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      {srst, run, pay_vld, sref_f, bidx} = 9'h100;
      {mode, inj, cnt, pay} = '0;
      emb = 6'h02;
      rbd = 11'h005;
      {fail_count, n_tests, cyc, inj_cyc, err_cyc} = '0;
      do_reset(2'h0);
      t_mode_off();
      do_reset(2'h2);
      t_lock();
      t_fec_err();
      t_hdr_loss();
      t_pilot_loss();
      report_and_stop();
   end

   // whole run is near 2200 cycles; a hang is cut well after that
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
endmodule

`default_nettype wire
